// ===== include/ucm_pkg.sv
package ucm_pkg;
  // Register byte offsets
  localparam logic [7:0] SelectOff = 8'h00;
  localparam logic [7:0] ControlOff = 8'h04;
  localparam logic [7:0] SplitOff = 8'h08;
  localparam logic [7:0] VbusSplitOff = 8'h0c;
  localparam logic [7:0] StatusOff = 8'h10;
  localparam logic [7:0] IrqStatusOff = 8'h14;
  localparam logic [7:0] IrqEnableOff = 8'h18;
  localparam logic [7:0] IrqClearOff = 8'h1c;
  localparam logic [7:0] SwitchOff = 8'h20;
  localparam logic [7:0] ApplyOff = 8'h24;
  // Control register fields
  localparam int CtlFlipBit = 0;
  localparam int CtlKeepAliveBit = 1;
  localparam int CtlSplitBit = 2;
  localparam int CtlAutoOrientBit = 3;
  // Split assignment: eight groups, two bits each
  localparam int NumGroups = 9;
  localparam int GrpSsA = 0;
  localparam int GrpSsB = 1;
  localparam int GrpHsA = 2;
  localparam int GrpHsB = 3;
  localparam int GrpCc1 = 4;
  localparam int GrpCc2 = 5;
  localparam int GrpSbu1 = 6;
  localparam int GrpSbu2 = 7;
  localparam int GrpEnBase = 16;
  // Interrupt event bits
  localparam int EvFault = 0;
  localparam int EvApplied = 1;
  localparam int EvOrient = 2;
  // Reset values and apply key
  localparam logic [1:0] SelectReset = 2'h0;
  localparam logic [3:0] ControlReset = 4'h8;
  localparam logic [31:0] SplitReset = 32'h00000000;
  localparam logic [3:0] VbusSplitReset = 4'h0;
  localparam logic [31:0] ApplyKey = 32'h00000001;
endpackage

// ===== rtl/ucm_usb_c_port_mux_control.sv
`timescale 1ns/1ps
module ucm_usb_c_port_mux_control
  import ucm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ccOrientFlipped,
  input wire logic overTemp,
  input wire logic [3:0] overCurrent,
  output logic [3:0] ssAEnable,
  output logic [3:0] ssBEnable,
  output logic [3:0] hsAEnable,
  output logic [3:0] hsBEnable,
  output logic [3:0] cc1Enable,
  output logic [3:0] cc2Enable,
  output logic [3:0] sbu1Enable,
  output logic [3:0] sbu2Enable,
  output logic [3:0] vbusEnable,
  output logic sideSwap,
  output logic [3:0] keepAliveCharge,
  output logic [3:0] dedicatedChargePortMode,
  output logic irq
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [1:0] select_reg;
  logic [3:0] control_reg;
  logic [31:0] split_reg;
  logic [3:0] vbusSplit_reg;
  logic [2:0] irqStatus_reg;
  logic [2:0] irqEnable_reg;
  logic [3:0] kacLatched_reg;
  logic orientPrev_reg;
  logic applyPend_reg;
  logic [35:0] switchState;
  logic addrPhase;

  assign addrPhase = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers (staged, except the keep-alive bit and the split bit's keep-alive cut, which act at once)
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      select_reg <= SelectReset;
      control_reg <= ControlReset;
      split_reg <= SplitReset;
      vbusSplit_reg <= VbusSplitReset;
    end else if (wrPend_reg) begin
      case (wrAddr_reg)
        SelectOff: begin
          select_reg <= hwdata[1:0];
        end
        ControlOff: begin
          control_reg <= hwdata[3:0];
        end
        SplitOff: begin
          split_reg <= hwdata;
        end
        VbusSplitOff: begin
          vbusSplit_reg <= hwdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      applyPend_reg <= 1'b0;
    end else begin
      applyPend_reg <= wrPend_reg && (wrAddr_reg == ApplyOff)
        && (hwdata == ApplyKey);
    end
  end

  // ----------------------------------------
  // Routing computation
  // ----------------------------------------
  logic flipEff;
  logic [3:0] selOneHot;
  logic [3:0] grpMask [NumGroups-1];
  logic [3:0] vbusRoute;

  // Cable orientation combined with the flip setting
  assign flipEff = control_reg[CtlFlipBit]
    ^ (control_reg[CtlAutoOrientBit] & ccOrientFlipped);
  assign selOneHot = 4'h1 << select_reg;

  genvar g;
  generate
    for (g = 0; g < NumGroups - 1; g++) begin : gGroup
      always_comb begin
        if (control_reg[CtlSplitBit]) begin
          grpMask[g] = split_reg[GrpEnBase + g]
            ? (4'h1 << split_reg[2*g +: 2]) : 4'h0;
        end else begin
          grpMask[g] = selOneHot;
        end
      end
    end
  endgenerate

  assign vbusRoute = control_reg[CtlSplitBit] ? vbusSplit_reg
    : selOneHot;

  // Side A and B swapped for every paired group
  always_comb begin
    switchState[3:0] = flipEff ? grpMask[GrpSsB] : grpMask[GrpSsA];
    switchState[7:4] = flipEff ? grpMask[GrpSsA] : grpMask[GrpSsB];
    switchState[11:8] = flipEff ? grpMask[GrpHsB] : grpMask[GrpHsA];
    switchState[15:12] = flipEff ? grpMask[GrpHsA] : grpMask[GrpHsB];
    switchState[19:16] = flipEff ? grpMask[GrpCc2] : grpMask[GrpCc1];
    switchState[23:20] = flipEff ? grpMask[GrpCc1] : grpMask[GrpCc2];
    switchState[27:24] = flipEff ? grpMask[GrpSbu2] : grpMask[GrpSbu1];
    switchState[31:28] = flipEff ? grpMask[GrpSbu1] : grpMask[GrpSbu2];
    switchState[35:32] = vbusRoute;
  end

  // ----------------------------------------
  // Switch outputs, updated all at once
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ssAEnable <= 4'h0;
      ssBEnable <= 4'h0;
      hsAEnable <= 4'h0;
      hsBEnable <= 4'h0;
      cc1Enable <= 4'h0;
      cc2Enable <= 4'h0;
      sbu1Enable <= 4'h0;
      sbu2Enable <= 4'h0;
      vbusEnable <= 4'h0;
      sideSwap <= 1'b0;
    end else if (applyPend_reg) begin
      ssAEnable <= switchState[3:0];
      ssBEnable <= switchState[7:4];
      hsAEnable <= switchState[11:8];
      hsBEnable <= switchState[15:12];
      cc1Enable <= switchState[19:16];
      cc2Enable <= switchState[23:20];
      sbu1Enable <= switchState[27:24];
      sbu2Enable <= switchState[31:28];
      vbusEnable <= switchState[35:32];
      sideSwap <= flipEff;
    end
  end

  // ----------------------------------------
  // Keep-alive charging
  // ----------------------------------------
  logic kacActive;
  logic [3:0] kacWant;
  logic [3:0] selApplied_reg;
  logic splitApplied_reg;
  logic [3:0] selNow;
  logic splitNow;

  // Selection actually on the switches, moving in the apply cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selApplied_reg <= 4'h1 << SelectReset;
      splitApplied_reg <= 1'b0;
    end else if (applyPend_reg) begin
      selApplied_reg <= selOneHot;
      splitApplied_reg <= control_reg[CtlSplitBit];
    end
  end

  assign selNow = applyPend_reg ? selOneHot : selApplied_reg;
  assign splitNow = applyPend_reg ? control_reg[CtlSplitBit]
    : splitApplied_reg;

  // Split mode, staged or applied, forces keep-alive off
  assign kacActive = control_reg[CtlKeepAliveBit]
    && !control_reg[CtlSplitBit] && !splitNow;
  // Every channel except the one switched to the common port
  assign kacWant = kacActive ? ~selNow : 4'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kacLatched_reg <= 4'h0;
    end else begin
      if (!kacActive) begin
        kacLatched_reg <= 4'h0;
      end else begin
        kacLatched_reg <= kacLatched_reg | overCurrent
          | {4{overTemp}};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keepAliveCharge <= 4'h0;
      dedicatedChargePortMode <= 4'h0;
    end else begin
      keepAliveCharge <= kacWant & ~kacLatched_reg
        & ~overCurrent & ~{4{overTemp}};
      dedicatedChargePortMode <= kacWant;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [2:0] irqEvents;
  logic [2:0] irqClear;

  assign irqEvents = {ccOrientFlipped != orientPrev_reg, applyPend_reg,
    kacActive && |((overCurrent | {4{overTemp}}) & ~kacLatched_reg)};
  assign irqClear = (wrPend_reg && wrAddr_reg == IrqClearOff)
    ? hwdata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      orientPrev_reg <= 1'b0;
      irqStatus_reg <= 3'h0;
      irqEnable_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      orientPrev_reg <= ccOrientFlipped;
      irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvents;
      if (wrPend_reg && wrAddr_reg == IrqEnableOff) begin
        irqEnable_reg <= hwdata[2:0];
      end
      irq <= |(((irqStatus_reg & ~irqClear) | irqEvents) & irqEnable_reg);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdMux;

  always_comb begin
    case (haddr[7:0])
      SelectOff: rdMux = {30'h0, select_reg};
      ControlOff: rdMux = {28'h0, control_reg};
      SplitOff: rdMux = split_reg;
      VbusSplitOff: rdMux = {28'h0, vbusSplit_reg};
      StatusOff: rdMux = {23'h0, ccOrientFlipped, kacLatched_reg,
        keepAliveCharge};
      IrqStatusOff: rdMux = {29'h0, irqStatus_reg};
      IrqEnableOff: rdMux = {29'h0, irqEnable_reg};
      SwitchOff: rdMux = {sbu2Enable, sbu1Enable, cc2Enable, cc1Enable,
        hsBEnable, hsAEnable, ssBEnable, ssAEnable};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdMux;
    end
  end

endmodule

// ===== verif/ucm_assertions.sv
`timescale 1ns/1ps
module ucm_assertions
  import ucm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic overTemp,
  input wire logic [3:0] overCurrent,
  input wire logic [3:0] ssAEnable,
  input wire logic [3:0] ssBEnable,
  input wire logic [3:0] cc1Enable,
  input wire logic [3:0] sbu2Enable,
  input wire logic [3:0] vbusEnable,
  input wire logic sideSwap,
  input wire logic [3:0] keepAliveCharge,
  input wire logic [3:0] dedicatedChargePortMode
);
  // ----------
  // Apply tracking
  // ----------
  logic applyData;
  logic applyDone;
  wire logic [12:0] sw = {ssAEnable, ssBEnable, vbusEnable, sideSwap};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      applyData <= 1'b0;
      applyDone <= 1'b0;
    end else begin
      applyData <= hsel & hready & htrans[1] & hwrite &
        (haddr[7:0] == ApplyOff);
      applyDone <= applyData & (hwdata == ApplyKey);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------
  // Checks
  // ----------
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  temp_cut_a: assert property (
    overTemp |=> keepAliveCharge == 4'h0)
    else $error("charge on after over-temperature");
  oc_cut_a: assert property (
    |overCurrent |=> (keepAliveCharge & $past(overCurrent)) == 4'h0)
    else $error("charge on after over-current");
  ka_rise_a: assert property (
    |(keepAliveCharge & ~$past(keepAliveCharge)) |-> !$past(overTemp))
    else $error("charge rose during over-temperature");
  dcp_cover_a: assert property (
    (keepAliveCharge & ~dedicatedChargePortMode) == 4'h0)
    else $error("charge without charge port mode");
  one_hot_a: assert property ($onehot0(ssAEnable) &&
    $onehot0(ssBEnable) && $onehot0(cc1Enable) && $onehot0(sbu2Enable))
    else $error("group on two channels");
  switch_atomic_a: assert property (
    $changed(sw) |-> $past(applyDone))
    else $error("switches moved without apply");
  charge_apart_a: assert property (
    (keepAliveCharge & vbusEnable) == 4'h0)
    else $error("charge on a connected channel");
endmodule

// ===== verif/ucm_port_model.sv
`timescale 1ns/1ps
module ucm_port_model (
  input wire logic clk,
  input wire logic flipIn,
  input wire logic tempIn,
  input wire logic [3:0] loadIn,
  input wire logic [3:0] keepAliveCharge,
  output logic ccOrientFlipped,
  output logic overTemp,
  output logic [3:0] overCurrent
);
  always_ff @(posedge clk) begin
    ccOrientFlipped <= flipIn;
    overTemp <= tempIn;
  end
  // Over-current only where charge power flows
  always_ff @(posedge clk) begin
    overCurrent <= loadIn & keepAliveCharge;
  end
endmodule

// ===== verif/ucm_usb_c_port_mux_control_tb.sv
`timescale 1ns/1ps
bind ucm_usb_c_port_mux_control ucm_assertions chk_u (.clk, .resetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .overTemp, .overCurrent, .ssAEnable, .ssBEnable, .cc1Enable,
  .sbu2Enable, .vbusEnable, .sideSwap, .keepAliveCharge,
  .dedicatedChargePortMode);
module ucm_usb_c_port_mux_control_tb
  import ucm_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, sideSwap, ccOrientFlipped, overTemp;
  logic [3:0] overCurrent, ssAEnable, ssBEnable, hsAEnable, hsBEnable;
  logic [3:0] cc1Enable, cc2Enable, sbu1Enable, sbu2Enable, vbusEnable;
  logic [3:0] keepAliveCharge, dedicatedChargePortMode;
  logic [3:0] loadIn = 4'h0;
  logic flipIn = 1'b0;
  logic tempIn = 1'b0;
  logic rdPh = 1'b0;
  logic lk = 1'b0;
  logic [31:0] q[$];
  int fail_count = 0;
  int checked = 0;
  wire logic hready = hreadyout;
  wire logic [31:0] ob1 = {ssAEnable, ssBEnable, hsAEnable, hsBEnable,
    cc1Enable, cc2Enable, sbu1Enable, sbu2Enable};
  wire logic [31:0] ob2 = {12'h0, dedicatedChargePortMode, 3'h0, irq,
    keepAliveCharge, vbusEnable, 3'h0, sideSwap};
  initial forever #50 clk = ~clk;
  ucm_usb_c_port_mux_control dut (.clk, .resetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .ccOrientFlipped, .overTemp, .overCurrent, .ssAEnable, .ssBEnable,
    .hsAEnable, .hsBEnable, .cc1Enable, .cc2Enable, .sbu1Enable,
    .sbu2Enable, .vbusEnable, .sideSwap, .keepAliveCharge,
    .dedicatedChargePortMode, .irq);
  ucm_port_model pm (.clk, .flipIn, .tempIn, .loadIn, .keepAliveCharge,
    .ccOrientFlipped, .overTemp, .overCurrent);
  // ----------
  // Bus and compare tasks
  // ----------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !w;
    do @(posedge clk); while (!hready);
    rdPh <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic look(input logic [31:0] e1, input logic [31:0] e2);
    repeat (4) @(posedge clk);
    q.push_back(e1);
    q.push_back(e2);
    lk <= 1'b1;
    @(posedge clk);
    lk <= 1'b0;
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (rdPh) chk(hrdata, q.pop_front());
    if (lk) begin
      chk(ob1, q.pop_front());
      chk(ob2, q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
  // ----------
  // Tests
  // ----------
  initial begin
    logic [3:0] e;
    logic r;
    void'($urandom(43143));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(ControlOff, {28'h0, ControlReset});
    rd(8'h28, 32'h0);
    rd(IrqClearOff, 32'h0);
    $display("test 1 done");
    for (int i = 0; i < 8; i++) begin
      r = 1'($urandom % 2);
      flipIn <= r;
      e = 4'h1 << i[1:0];
      wr(SelectOff, {30'h0, i[1:0]});
      wr(ControlOff, {28'h0, 3'b100, i[2]});
      wr(ApplyOff, ApplyKey);
      look({8{e}}, {24'h0, e, 3'h0, i[2] ^ r});
    end
    $display("test 2 done");
    flipIn <= 1'b0;
    wr(SplitOff, 32'h007fe4e4);
    for (int f = 0; f < 2; f++) begin
      wr(VbusSplitOff, f ? 32'h4 : 32'h0);
      wr(ControlOff, {29'h3, f[0]});
      wr(ApplyOff, ApplyKey);
      look(f ? 32'h21842104 : 32'h12481240,
        f ? 32'h41 : 32'h0);
    end
    $display("test 3 done");
    wr(SelectOff, 32'h1);
    wr(ControlOff, 32'h2);
    wr(ApplyOff, ApplyKey);
    wr(IrqClearOff, 32'h7);
    wr(IrqEnableOff, 32'h1);
    look(32'h22222222, 32'h000d0d20);
    loadIn <= 4'h4;
    look(32'h22222222, 32'h000d1920);
    loadIn <= 4'h0;
    rd(StatusOff, 32'h49);
    rd(IrqStatusOff, 32'h1);
    wr(IrqClearOff, 32'h1);
    look(32'h22222222, 32'h000d0920);
    wr(ControlOff, 32'h0);
    wr(ControlOff, 32'h2);
    look(32'h22222222, 32'h000d0d20);
    tempIn <= 1'b1;
    look(32'h22222222, 32'h000d1020);
    $display("test 4 done");
    results();
  end
endmodule
